// File: common/i2c_mode_params.svh
`ifndef I2C_MODE_PARAMS_SVH
`define I2C_MODE_PARAMS_SVH
// ==========================================================================
// Register byte offsets.
`define OFS_CTRL 8'h00
`define OFS_FORMAT 8'h04
`define OFS_OWN_ADDR 8'h08
`define OFS_TX_DATA 8'h0c
`define OFS_RX_BUF 8'h10
`define OFS_STATUS 8'h14
`define OFS_MASK 8'h18
// ==========================================================================
// Control field positions.
`define CTRL_ICE 7
`define CTRL_RECEPTION_DISABLE_BIT 6
`define CTRL_MST 5
`define CTRL_TRS 4
`define CTRL_RESET 8'h00
// ==========================================================================
// Status and mask bit positions.
`define ST_RX_FULL 0
`define ST_TX_END 1
`define ST_ARB_LOST 2
`define ST_OVERRUN 3
`define ST_ADDR_MATCH 4
`define ST_WIDTH 5
// ==========================================================================
// Timing.
`define CLK_PERIOD_NS 50
`define SCL_HALF_NS 2500
`define SCL_HALF_CYC (`SCL_HALF_NS / `CLK_PERIOD_NS)
`define DATA_BITS 8
`endif

// File: common/i2c_mode_pkg.sv
package i2c_mode_pkg;
  typedef enum logic [2:0] {
    XF_IDLE = 3'b001,
    XF_DATA = 3'b010,
    XF_ACK = 3'b100
  } xfer_state_t;
  typedef enum logic {
    FMT_TWO_WIRE = 1'b0,
    FMT_CLOCKED = 1'b1
  } frame_fmt_t;
endpackage : i2c_mode_pkg

// File: design/i2c_mode_control.sv
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_mode_params.svh"
// Contract
// - Interface enable set: clock and data pins driven by bus, transfers allowed.
// - Interface enable clear: module halted, pins returned to port function.
// - Receive buffer read while receiving: next reception runs or is suppressed.
// - Two-wire master losing arbitration clears master and transmit selects.
// - Slave receive address match with read bit sets transmit select.
// - Clocked-format master overrun clears master select, entering slave receive.
// - Clocked format with master select drives the serial clock output.
// - Select pair 00 is slave receive, 01 is slave transmit.
// - Master, transmit and reception-disable bits are read/write, reset to 0.
module i2c_mode_control
  import i2c_mode_pkg::*;
#(
  parameter int HALF_CYC = `SCL_HALF_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic port_function,
  output logic irq
);
  // The master clock counter is 16 bits wide.
  if (HALF_CYC < 1 || HALF_CYC > 65536) begin : g_half_cyc_check
    $error("HALF_CYC must lie between 1 and 65536");
  end

  // ========================================================================
  // Bus slave.
  logic aw_ff, w_ff, bvalid_ff, arready_ff, rvalid_ff, awready_ff, wready_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic wr_go, rd_go, wr_ok, rd_ok;
  logic [7:0] ctrl_rd;
  logic ice_ff, reception_disable_bit_ff, mst_ff, trs_ff, fmt_ff, hold_ff;
  logic [6:0] own_addr_ff;
  logic [7:0] tx_data_ff, rx_buf_ff;
  logic tx_full_ff, rx_full_ff;
  logic [`ST_WIDTH-1:0] status_ff, mask_ff, ev;
  logic irq_ff;

  assign wr_go = aw_ff && w_ff && !bvalid_ff;
  assign rd_go = s_axi_arvalid && arready_ff;
  assign wr_ok = (awaddr_ff[7:5] == 3'h0) && (awaddr_ff[4:2] != 3'h7);
  assign rd_ok = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[4:2] != 3'h7);
  assign ctrl_rd = {ice_ff, reception_disable_bit_ff, mst_ff, trs_ff, 4'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      awready_ff <= 1'b1;
      awaddr_ff <= 8'h00;
    end else if (s_axi_awvalid && awready_ff) begin
      aw_ff <= 1'b1;
      awready_ff <= 1'b0;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_ff <= 1'b0;
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_ff <= 1'b0;
      wready_ff <= 1'b1;
      wdata_ff <= 32'h0;
    end else if (s_axi_wvalid && wready_ff) begin
      w_ff <= 1'b1;
      wready_ff <= 1'b0;
      wdata_ff <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
    end else if (wr_go) begin
      w_ff <= 1'b0;
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_ok ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  logic wr_ctrl, wr_fmt, wr_addr, wr_tx, wr_st, wr_mask, rd_rx;
  assign wr_ctrl = wr_go && awaddr_ff == `OFS_CTRL;
  assign wr_fmt = wr_go && awaddr_ff == `OFS_FORMAT;
  assign wr_addr = wr_go && awaddr_ff == `OFS_OWN_ADDR;
  assign wr_tx = wr_go && awaddr_ff == `OFS_TX_DATA;
  assign wr_st = wr_go && awaddr_ff == `OFS_STATUS;
  assign wr_mask = wr_go && awaddr_ff == `OFS_MASK;
  assign rd_rx = rd_go && s_axi_araddr == `OFS_RX_BUF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= 2'h0;
    end else if (rd_go) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_ok ? 2'h0 : 2'h2;
      unique case (s_axi_araddr)
        `OFS_CTRL: rdata_ff <= {24'h0, ctrl_rd};
        `OFS_FORMAT: rdata_ff <= {31'h0, fmt_ff};
        `OFS_OWN_ADDR: rdata_ff <= {24'h0, own_addr_ff, 1'b0};
        `OFS_TX_DATA: rdata_ff <= {24'h0, tx_data_ff};
        `OFS_RX_BUF: rdata_ff <= {24'h0, rx_buf_ff};
        `OFS_STATUS: rdata_ff <= {27'h0, status_ff};
        `OFS_MASK: rdata_ff <= {27'h0, mask_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end else if (rvalid_ff) begin
      if (s_axi_rready) rvalid_ff <= 1'b0;
    end else begin
      arready_ff <= 1'b1;
    end
  end

  // ========================================================================
  // Pin sampling: three stages, a change counts once stages two and three agree.
  logic [2:0] scl_sy_ff, sda_sy_ff;
  logic scl_lvl_ff, sda_lvl_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sy_ff <= 3'h7;
      sda_sy_ff <= 3'h7;
      scl_lvl_ff <= 1'b1;
      sda_lvl_ff <= 1'b1;
    end else begin
      scl_sy_ff <= {scl_sy_ff[1:0], scl_i};
      sda_sy_ff <= {sda_sy_ff[1:0], sda_i};
      if (scl_sy_ff[1] == scl_sy_ff[2]) scl_lvl_ff <= scl_sy_ff[2];
      if (sda_sy_ff[1] == sda_sy_ff[2]) sda_lvl_ff <= sda_sy_ff[2];
    end
  end

  logic scl_new, sda_new, scl_rise, scl_fall, start_det, stop_det, two_wire;
  assign scl_new = (scl_sy_ff[1] == scl_sy_ff[2]) ? scl_sy_ff[2] : scl_lvl_ff;
  assign sda_new = (sda_sy_ff[1] == sda_sy_ff[2]) ? sda_sy_ff[2] : sda_lvl_ff;
  assign scl_rise = scl_new && !scl_lvl_ff;
  assign scl_fall = !scl_new && scl_lvl_ff;
  assign two_wire = fmt_ff == FMT_TWO_WIRE;
  assign start_det = two_wire && scl_lvl_ff && scl_new && sda_lvl_ff && !sda_new;
  assign stop_det = two_wire && scl_lvl_ff && scl_new && !sda_lvl_ff && sda_new;

  // ========================================================================
  // Frame engine.
  xfer_state_t state_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] rx_sh_ff, tx_sh_ff, rx_byte;
  logic addr_ph_ff, ack_drv_ff, go, byte_done, arb_lost, overrun, addr_hit, rx_take;
  logic [1:0] sel;

  // Select pair decode: 00 slave rx, 01 slave tx, 10 master rx, 11 master tx.
  assign sel = {mst_ff, trs_ff};
  assign go = !hold_ff && (sel[1] ? (!sel[0] || tx_full_ff) : !two_wire);
  assign rx_byte = {rx_sh_ff[6:0], sda_new};
  assign byte_done = state_ff == XF_DATA && scl_rise && bit_cnt_ff == 3'(`DATA_BITS - 1);
  assign arb_lost = two_wire && mst_ff && trs_ff && state_ff == XF_DATA && scl_rise
                    && tx_sh_ff[7] && !sda_new;
  assign rx_take = byte_done && (!trs_ff || addr_ph_ff);
  assign overrun = rx_take && !two_wire && mst_ff && rx_full_ff;
  assign addr_hit = byte_done && addr_ph_ff && two_wire && !mst_ff
                    && rx_byte[7:1] == own_addr_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn || !ice_ff) begin
      state_ff <= XF_IDLE;
      bit_cnt_ff <= 3'h0;
      addr_ph_ff <= 1'b0;
    end else if (start_det && !mst_ff) begin
      state_ff <= XF_DATA;
      bit_cnt_ff <= 3'h0;
      addr_ph_ff <= 1'b1;
    end else if (stop_det || arb_lost) begin
      state_ff <= XF_IDLE;
      addr_ph_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        XF_IDLE: if (go) begin
          state_ff <= XF_DATA;
          bit_cnt_ff <= 3'h0;
        end
        XF_DATA: if (scl_rise) begin
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          if (byte_done) begin
            state_ff <= two_wire ? XF_ACK : XF_IDLE;
          end
        end
        // The address flag lasts through the acknowledge, so a read address is answered too.
        XF_ACK: if (scl_rise) begin
          state_ff <= (mst_ff || hold_ff) ? XF_IDLE : XF_DATA;
          bit_cnt_ff <= 3'h0;
          addr_ph_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sh_ff <= 8'h00;
      tx_sh_ff <= 8'hff;
      ack_drv_ff <= 1'b0;
    end else begin
      if (state_ff == XF_DATA && scl_rise) rx_sh_ff <= rx_byte;
      if ((state_ff != XF_DATA) && (go || state_ff == XF_ACK) && trs_ff) begin
        tx_sh_ff <= tx_full_ff ? tx_data_ff : 8'hff;
      end else if (state_ff == XF_DATA && scl_fall && bit_cnt_ff != 3'h0) begin
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
      end
      if (state_ff != XF_ACK) ack_drv_ff <= 1'b0;
      else if (scl_fall) ack_drv_ff <= !trs_ff || addr_ph_ff;
    end
  end

  // ========================================================================
  // Control register and buffers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ice_ff, reception_disable_bit_ff} <= 2'b00;
    end else if (wr_ctrl) begin
      ice_ff <= wdata_ff[`CTRL_ICE];
      reception_disable_bit_ff <= wdata_ff[`CTRL_RECEPTION_DISABLE_BIT];
    end
  end

  // Hardware events win over a software write in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mst_ff <= 1'b0;
    end else if (arb_lost || overrun) begin
      mst_ff <= 1'b0;
    end else if (wr_ctrl) begin
      mst_ff <= wdata_ff[`CTRL_MST];
    end
  end

  // A software write mid-frame is obeyed at once; callers keep it between frames.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trs_ff <= 1'b0;
    end else if (arb_lost) begin
      trs_ff <= 1'b0;
    end else if (addr_hit && rx_byte[0]) begin
      trs_ff <= 1'b1;
    end else if (wr_ctrl) begin
      trs_ff <= wdata_ff[`CTRL_TRS];
    end
  end

  // Suppression stays until software clears the disable bit or the interface.
  always_ff @(posedge aclk) begin
    if (!aresetn || !ice_ff || (wr_ctrl && !wdata_ff[`CTRL_RECEPTION_DISABLE_BIT])) begin
      hold_ff <= 1'b0;
    end else if (rd_rx && !trs_ff) begin
      hold_ff <= reception_disable_bit_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fmt_ff <= 1'b0;
      own_addr_ff <= 7'h00;
      mask_ff <= '0;
    end else begin
      if (wr_fmt) fmt_ff <= wdata_ff[0];
      if (wr_addr) own_addr_ff <= wdata_ff[7:1];
      if (wr_mask) mask_ff <= wdata_ff[`ST_WIDTH-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_data_ff <= 8'h00;
      tx_full_ff <= 1'b0;
    end else if (wr_tx) begin
      tx_data_ff <= wdata_ff[7:0];
      tx_full_ff <= 1'b1;
    end else if (state_ff != XF_DATA && (go || state_ff == XF_ACK) && trs_ff) begin
      tx_full_ff <= 1'b0;
    end
  end

  // An overrun keeps the unread byte; the new one is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_ff <= 8'h00;
      rx_full_ff <= 1'b0;
    end else if (rx_take && !overrun) begin
      rx_buf_ff <= rx_byte;
      rx_full_ff <= 1'b1;
    end else if (rd_rx) begin
      rx_full_ff <= 1'b0;
    end
  end

  // ========================================================================
  // Events and interrupt.
  always_comb begin
    ev = '0;
    ev[`ST_RX_FULL] = rx_take && !overrun;
    ev[`ST_TX_END] = byte_done && trs_ff && !addr_ph_ff;
    ev[`ST_ARB_LOST] = arb_lost;
    ev[`ST_OVERRUN] = overrun;
    ev[`ST_ADDR_MATCH] = addr_hit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= (status_ff & ~(wr_st ? wdata_ff[`ST_WIDTH-1:0] : '0)) | ev;
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // ========================================================================
  // Master clock and pin drive.
  logic mclk_ff, scl_o_ff, scl_oe_n_ff, sda_o_ff, sda_oe_n_ff, port_ff;
  logic [15:0] mcnt_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || !mst_ff || state_ff == XF_IDLE) begin
      mclk_ff <= 1'b1;
      mcnt_ff <= 16'h0;
    end else if (mcnt_ff == 16'(HALF_CYC - 1)) begin
      mclk_ff <= !mclk_ff;
      mcnt_ff <= 16'h0;
    end else begin
      mcnt_ff <= mcnt_ff + 16'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_o_ff, scl_oe_n_ff, sda_o_ff, sda_oe_n_ff, port_ff} <= 5'b01011;
    end else if (!ice_ff) begin
      {scl_o_ff, scl_oe_n_ff, sda_o_ff, sda_oe_n_ff, port_ff} <= 5'b01011;
    end else begin
      port_ff <= 1'b0;
      if (!two_wire && mst_ff) begin
        scl_o_ff <= mclk_ff;
        scl_oe_n_ff <= 1'b0;
      end else begin
        scl_o_ff <= 1'b0;
        scl_oe_n_ff <= two_wire ? !((mst_ff && !mclk_ff) || (hold_ff && !mst_ff)) : 1'b1;
      end
      if (!two_wire) begin
        sda_o_ff <= tx_sh_ff[7];
        sda_oe_n_ff <= !trs_ff;
      end else begin
        sda_o_ff <= 1'b0;
        sda_oe_n_ff <= !(ack_drv_ff || (state_ff == XF_DATA && trs_ff && !addr_ph_ff
                         && !tx_sh_ff[7]));
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign scl_o = scl_o_ff;
  assign scl_oe_n = scl_oe_n_ff;
  assign sda_o = sda_o_ff;
  assign sda_oe_n = sda_oe_n_ff;
  assign port_function = port_ff;
  assign irq = irq_ff;
endmodule : i2c_mode_control
`default_nettype wire

// File: sim/i2c_far_master.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Far bus master; both lines are open drain and released between frames.
module i2c_far_master (
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_pd,
  output logic sda_pd
);
  initial begin
    scl_pd = 1'b0;
    sda_pd = 1'b0;
  end
  // A slave may stretch the clock, so the high phase waits for the wire.
  // The low phase outlasts the block's pin sampling delay, so its reply settles first.
  task automatic tick(output logic s);
    #260 scl_pd = 1'b0;
    wait (scl_w === 1'b1);
    #120 s = sda_w;
    scl_pd = 1'b1;
  endtask : tick
  task automatic frame(input logic [7:0] b, output logic ack);
    logic s;
    sda_pd = 1'b1;
    #200 scl_pd = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #20 sda_pd = ~b[i];
      tick(s);
    end
    #20 sda_pd = 1'b0;
    tick(ack);
    #20 sda_pd = 1'b1;
    #200 scl_pd = 1'b0;
    #200 sda_pd = 1'b0;
  endtask : frame
endmodule : i2c_far_master
`default_nettype wire

// File: sim/i2c_mode_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2c_mode_params.svh"
// ==========================================================================
// Port checks. Control and mask bits are mirrored from bus writes, since
// software alone changes the enable and reception-disable bits.
module i2c_mode_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic port_function,
  input wire logic irq
);
  logic [7:0] ctrl_ff;
  logic [4:0] mask_ff;
  logic [3:0] age_ff;
  logic rd_ctrl_ff;
  logic wr_go;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= 8'h00;
      mask_ff <= 5'h00;
    end else if (wr_go && s_axi_awaddr == `OFS_CTRL) begin
      ctrl_ff <= s_axi_wdata[7:0];
    end else if (wr_go && s_axi_awaddr == `OFS_MASK) begin
      mask_ff <= s_axi_wdata[4:0];
    end
  end
  // The age counter lets registered outputs settle before they are judged.
  always_ff @(posedge aclk) begin
    if (!aresetn || wr_go) begin
      age_ff <= 4'h0;
    end else if (age_ff != 4'hf) begin
      age_ff <= age_ff + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || (s_axi_rvalid && s_axi_rready)) begin
      rd_ctrl_ff <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_ctrl_ff <= (s_axi_araddr == `OFS_CTRL);
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    wr_go;
  endsequence
  sequence bad_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h1c;
  endsequence
  pins_free_a: assert property (
    port_function |-> scl_oe_n && sda_oe_n) else $error("pins driven while released");
  pin_owner_a: assert property (
    age_ff >= 4'h4 |-> port_function == !ctrl_ff[7]) else $error("pin owner wrong");
  ctrl_readback_a: assert property (
    s_axi_rvalid && rd_ctrl_ff && age_ff >= 4'h4 |-> s_axi_rdata[7:6] == ctrl_ff[7:6])
    else $error("control readback wrong");
  irq_masked_a: assert property (
    mask_ff == 5'h00 && age_ff >= 4'h4 |-> !irq) else $error("masked irq raised");
  write_answer_a: assert property (
    wr_taken |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  b_stands_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_stands_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  bad_read_a: assert property (
    bad_read |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read answered wrongly");
endmodule : i2c_mode_chk
bind i2c_mode_control i2c_mode_chk i2c_mode_chk_inst (.*);
`default_nettype wire

// File: sim/test_i2c_mode_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2c_mode_params.svh"
// ==========================================================================
// Bench for the mode control block.
module test_i2c_mode_control;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, d;
  logic [1:0] r;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, port_function, irq, p_scl, p_sda, ack;
  logic jam = 1'b0;
  wire logic scl_w;
  wire logic sda_w;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  // Jam pulls data low to make the block lose arbitration.
  assign scl_w = (scl_oe_n | scl_o) & ~p_scl;
  assign sda_w = (sda_oe_n | sda_o) & ~p_sda & ~jam;
  i2c_mode_control #(.HALF_CYC(2)) i2c_mode_control_inst (.*, .scl_i(scl_w), .sda_i(sda_w));
  i2c_far_master i2c_far_master_inst (.scl_w(scl_w), .sda_w(sda_w), .scl_pd(p_scl),
    .sda_pd(p_sda));
  initial begin
    forever #25 aclk = ~aclk;
  end
  task automatic test_done;
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic poll(input int b);
    for (int n = 0; n < 80; n++) begin
      rd(`OFS_STATUS);
      if (d[b] === 1'b1) break;
    end
    chk(d & (32'h1 << b), 32'h1 << b, "status bit not set");
  endtask : poll
  task automatic t_reset;
    rd(`OFS_CTRL);
    chk(d, 32'h0, "control reset value");
    chk({scl_oe_n, sda_oe_n, port_function}, 3'b111, "pins not released");
    rd(8'h1c);
    chk(32'(r), 32'h2, "unmapped read response");
    chk(d, 32'h0, "unmapped read data");
  endtask : t_reset
  task automatic t_modes;
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      v = (32'(i) << 4) | (32'(i & 1) << 6);
      wr(`OFS_CTRL, v);
      rd(`OFS_CTRL);
      chk(d, v, "mode select readback");
    end
  endtask : t_modes
  task automatic t_slave;
    wr(`OFS_OWN_ADDR, 32'h54);
    wr(`OFS_FORMAT, 32'h0);
    wr(`OFS_MASK, 32'h10);
    wr(`OFS_CTRL, 32'hc0);
    repeat (4) @(posedge aclk);
    chk(port_function, 1'b0, "pins not taken");
    chk(sda_o, 1'b0, "data pin not open drain");
    i2c_far_master_inst.frame(8'h54, ack);
    chk(ack, 1'b0, "no acknowledge");
    rd(`OFS_RX_BUF);
    chk(d, 32'h54, "receive buffer");
    repeat (8) @(posedge aclk);
    chk({scl_oe_n, scl_o}, 2'b00, "next reception not held");
    wr(`OFS_CTRL, 32'h80);
    repeat (8) @(posedge aclk);
    chk(scl_oe_n, 1'b1, "hold not released");
    wr(`OFS_STATUS, 32'h1f);
    i2c_far_master_inst.frame(8'h55, ack);
    rd(`OFS_CTRL);
    chk(d, 32'h90, "transmit select not set");
    chk(irq, 1'b1, "irq missing");
    wr(`OFS_STATUS, 32'h1f);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0, "irq not cleared");
    wr(`OFS_CTRL, 32'h0);
    repeat (4) @(posedge aclk);
    chk(port_function, 1'b1, "pins not returned");
  endtask : t_slave
  task automatic t_arb;
    wr(`OFS_MASK, 32'h4);
    jam <= 1'b1;
    wr(`OFS_CTRL, 32'hb0);
    wr(`OFS_TX_DATA, 32'hff);
    poll(`ST_ARB_LOST);
    jam <= 1'b0;
    rd(`OFS_CTRL);
    chk(d, 32'h80, "arbitration loss mode");
    chk(irq, 1'b1, "irq missing");
    wr(`OFS_STATUS, 32'h1f);
    wr(`OFS_CTRL, 32'h0);
  endtask : t_arb
  task automatic t_over;
    wr(`OFS_FORMAT, 32'h1);
    wr(`OFS_MASK, 32'h0);
    wr(`OFS_CTRL, 32'ha0);
    for (int n = 0; n < 100 && scl_oe_n !== 1'b0; n++) @(posedge aclk);
    chk(scl_oe_n, 1'b0, "clock not driven");
    poll(`ST_OVERRUN);
    rd(`OFS_CTRL);
    chk(d, 32'h80, "overrun mode");
    chk(irq, 1'b0, "masked irq raised");
  endtask : t_over
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_modes;
    t_slave;
    t_arb;
    t_over;
    test_done;
  end
endmodule : test_i2c_mode_control
`default_nettype wire
